/* File: logic/flash_seq_pkg.sv */
// Shared constants and types for both ends
`default_nettype none
package flash_seq_pkg;
  // ****************************************
  // Array geometry
  // ****************************************
  localparam int ROW_INSTR = 32;
  localparam int ROW_BYTES = 96;
  localparam int PANEL_ROWS = 128;
  localparam int INSTR_BITS = 24;
  localparam int ADDR_BITS = 24;
  localparam int LATCH_IDX_LSB = 1;
  localparam int LATCH_IDX_BITS = 5;
  localparam int ROW_ADDR_LSB = 6;
  localparam int PANEL_ADDR_LSB = 13;
  localparam logic [23:0] INSTR_ADDR_STEP = 24'h000002;
  localparam logic [5:0] ROW_FULL = 6'h20;

  // ****************************************
  // Function register selects and fields
  // ****************************************
  typedef enum logic [1:0] {
    sel_control = 2'h0,
    sel_addr_low = 2'h1,
    sel_addr_high = 2'h2,
    sel_key = 2'h3
  } sfr_sel_type;

  localparam int START_BIT = 15;
  localparam int PERMIT_BIT = 14;
  localparam int OP_LSB = 0;
  localparam int OP_BITS = 7;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] ADDR_LOW_RESET = 16'h0000;
  localparam logic [7:0] ADDR_HIGH_RESET = 8'h00;
  localparam logic [15:0] CONTROL_WMASK = 16'h407f;
  localparam logic [15:0] START_MASK = 16'h8000;
  localparam logic [6:0] OP_ERASE_ROW = 7'h41;
  localparam logic [6:0] OP_PROGRAM_ROW = 7'h01;
  localparam logic [15:0] CTRL_ERASE_CMD = 16'h4041;
  localparam logic [15:0] CTRL_PROGRAM_CMD = 16'h4001;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  localparam logic [1:0] KEY_NONE = 2'h0;
  localparam logic [1:0] KEY_HALF = 2'h1;
  localparam logic [1:0] KEY_OPEN = 2'h2;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 125;
  localparam int OP_TIME_MS = 2;
  localparam int OP_CYCLES = OP_TIME_MS * CLK_MHZ * 1000;
  localparam int TBL_WRITE_CYCLES = 2;
  localparam logic [1:0] NOP_LAST = 2'h1;

  // ****************************************
  // CPU end APB map
  // ****************************************
  localparam logic [11:0] CMD_OFF = 12'h000;
  localparam logic [11:0] ADDR_OFF = 12'h004;
  localparam logic [11:0] DATA_OFF = 12'h008;
  localparam logic [11:0] STATUS_OFF = 12'h00c;
  localparam int CMD_ERASE_BIT = 0;
  localparam int CMD_PROGRAM_BIT = 1;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_ALIGN_BIT = 1;
  localparam int ST_REFUSED_BIT = 2;
endpackage
`default_nettype wire

/* File: logic/flash_cpu_if.sv */
// Connection between the CPU end and the flash sequencer
`default_nettype none
interface flash_cpu_if;
  logic sfr_wr;
  flash_seq_pkg::sfr_sel_type sfr_sel;
  logic [15:0] sfr_wdata;
  logic [15:0] sfr_rdata;
  logic tbl_wr;
  logic tbl_high;
  logic [23:0] tbl_addr;
  logic [15:0] tbl_wdata;
  logic stall;

  modport flash_end (
    input sfr_wr, sfr_sel, sfr_wdata, tbl_wr, tbl_high, tbl_addr, tbl_wdata,
    output sfr_rdata, stall
  );
  modport cpu_end (
    output sfr_wr, sfr_sel, sfr_wdata, tbl_wr, tbl_high, tbl_addr, tbl_wdata,
    input sfr_rdata, stall
  );
endinterface
`default_nettype wire

/* File: logic/flash_self_write_sequencer.sv */
// Flash self-write sequencer
//
// How it works
// [RQ1] Rows hold 32 instructions, 96 bytes
// [RQ2] Panels hold 128 rows of instructions
// [RQ3] Erase one row; program 32 instructions
// [RQ4] Latches hold 32; host fills ascending first
// [RQ5] Host loads only row-aligned latch addresses
// [RQ6] Host issues 32 low, 32 high writes
// [RQ7] Table write takes two cycles, latches only
// [RQ8] Low address captures address bits 15:0
// [RQ9] High address captures address bits 23:16
// [RQ10] Software may write both address registers
// [RQ11] Key write-only; 0x55 then 0xaa unlock
// [RQ12] Operation lasts 2 ms, processor stalled
// [RQ13] Start bit 15 launches, hardware clears
// [RQ14] Control picks block, memory, op, start
// [RQ15] Host erase: configure, address, keys, start
// [RQ16] Host program: configure, keys, then start
// [RQ17] Control 0x4041 selects row erase
// [RQ18] Host waits two no-op cycles after start
// [RQ19] High-byte write keeps low source byte
// [RQ20] Low word bits 15:0, high 23:16
// [RQ21] Software sets start, never clears it
// [RQ22] Start needs permit and fresh key sequence
// [RQ23] Key and start refused while running
`default_nettype none
module flash_self_write_sequencer #(
  parameter int OP_CYCLES = flash_seq_pkg::OP_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  flash_cpu_if.flash_end bus,
  output logic flash_erase_start,
  output logic flash_program_start,
  output logic flash_busy,
  output logic [flash_seq_pkg::ADDR_BITS-flash_seq_pkg::PANEL_ADDR_LSB-1:0] flash_panel,
  output logic [flash_seq_pkg::PANEL_ADDR_LSB-flash_seq_pkg::ROW_ADDR_LSB-1:0] flash_row,
  output logic [flash_seq_pkg::ROW_INSTR*flash_seq_pkg::INSTR_BITS-1:0] flash_row_data
);

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_run = 2'b01,
    st_table = 2'b10
  } dev_state_type;

  typedef struct packed {
    dev_state_type state;
    logic [15:0] control;
    logic [15:0] addr_low;
    logic [7:0] addr_high;
    logic [1:0] key_step;
    logic [31:0] count;
    logic [flash_seq_pkg::ROW_INSTR-1:0][flash_seq_pkg::INSTR_BITS-1:0] latch;
    logic [15:0] rdata;
    logic erase_start;
    logic program_start;
  } dev_regs_type;

  dev_regs_type r_reg;
  dev_regs_type r_next;

  // ****************************************
  // Operation decode
  // ****************************************
  function automatic logic op_known(input logic [15:0] value);
    logic [6:0] op;
    op = value[flash_seq_pkg::OP_LSB +: flash_seq_pkg::OP_BITS];
    return (op == flash_seq_pkg::OP_ERASE_ROW) || (op == flash_seq_pkg::OP_PROGRAM_ROW);
  endfunction

  function automatic logic op_is_erase(input logic [15:0] value);
    return value[flash_seq_pkg::OP_LSB +: flash_seq_pkg::OP_BITS] == flash_seq_pkg::OP_ERASE_ROW;
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [flash_seq_pkg::LATCH_IDX_BITS-1:0] idx;
    logic [15:0] wdata;
    idx = bus.tbl_addr[flash_seq_pkg::LATCH_IDX_LSB +: flash_seq_pkg::LATCH_IDX_BITS];
    wdata = bus.sfr_wdata;
    r_next = r_reg;
    r_next.erase_start = 1'b0;
    r_next.program_start = 1'b0;

    // Key always reads as zero
    // [RQ11] key write-only
    case (bus.sfr_sel)
      flash_seq_pkg::sel_control: r_next.rdata = r_reg.control;
      flash_seq_pkg::sel_addr_low: r_next.rdata = r_reg.addr_low;
      flash_seq_pkg::sel_addr_high: r_next.rdata = {8'h00, r_reg.addr_high};
      default: r_next.rdata = 16'h0000;
    endcase

    case (r_reg.state)
      st_idle: begin
        if (bus.tbl_wr) begin
          // [RQ8] capture low address
          r_next.addr_low = bus.tbl_addr[15:0];
          // [RQ9] capture high address
          r_next.addr_high = bus.tbl_addr[23:16];
          // Any table write breaks a half-done unlock
          // [RQ22] cancel unlock
          r_next.key_step = flash_seq_pkg::KEY_NONE;
          // [RQ4] latch by instruction slot
          if (bus.tbl_high) begin
            // [RQ19] keep low source byte
            // [RQ20] high byte lane
            r_next.latch[idx][23:16] = bus.tbl_wdata[7:0];
          end else begin
            // [RQ20] low word lane
            r_next.latch[idx][15:0] = bus.tbl_wdata;
          end
          // [RQ7] second cycle stalls
          r_next.state = st_table;
        end else if (bus.sfr_wr) begin
          // [RQ22] intervening write cancels
          r_next.key_step = flash_seq_pkg::KEY_NONE;
          case (bus.sfr_sel)
            flash_seq_pkg::sel_control: begin
              // Start bit is outside the mask, so writes never clear it
              // [RQ21] start not clearable
              r_next.control = (r_reg.control & ~flash_seq_pkg::CONTROL_WMASK) |
                (wdata & flash_seq_pkg::CONTROL_WMASK);
              // [RQ22] guarded start
              if (wdata[flash_seq_pkg::START_BIT] && wdata[flash_seq_pkg::PERMIT_BIT] &&
                  r_reg.key_step == flash_seq_pkg::KEY_OPEN && op_known(wdata)) begin
                // [RQ13] start launches
                r_next.control[flash_seq_pkg::START_BIT] = 1'b1;
                r_next.state = st_run;
                r_next.count = 32'h0;
                // [RQ17] erase opcode
                // [RQ3] one row per operation
                r_next.erase_start = op_is_erase(wdata);
                r_next.program_start = !op_is_erase(wdata);
              end
            end
            flash_seq_pkg::sel_addr_low: begin
              // [RQ10] direct address write
              r_next.addr_low = wdata;
            end
            flash_seq_pkg::sel_addr_high: begin
              // [RQ10] direct address write
              r_next.addr_high = wdata[7:0];
            end
            default: begin
              // [RQ11] consecutive key pair
              if (wdata[7:0] == flash_seq_pkg::KEY_FIRST) begin
                r_next.key_step = flash_seq_pkg::KEY_HALF;
              end else if (wdata[7:0] == flash_seq_pkg::KEY_SECOND &&
                  r_reg.key_step == flash_seq_pkg::KEY_HALF) begin
                r_next.key_step = flash_seq_pkg::KEY_OPEN;
              end
            end
          endcase
        end
      end
      st_table: begin
        r_next.state = st_idle;
      end
      st_run: begin
        // Writes dropped; a stalled CPU issues none
        // [RQ23] refuse while running
        // [RQ12] timed cycle
        if (r_reg.count == 32'(OP_CYCLES - 1)) begin
          // [RQ13] hardware clears start
          r_next.control[flash_seq_pkg::START_BIT] = 1'b0;
          r_next.state = st_idle;
        end else begin
          r_next.count = r_reg.count + 32'h1;
        end
      end
      default: begin
        r_next.state = st_idle;
      end
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // [RQ12] stall whole operation
  assign bus.stall = r_reg.state != st_idle;
  assign bus.sfr_rdata = r_reg.rdata;
  assign flash_erase_start = r_reg.erase_start;
  assign flash_program_start = r_reg.program_start;
  assign flash_busy = r_reg.state == st_run;

  // In-row bits ignored: any address in the row selects it
  // [RQ1] row geometry
  // [RQ2] panel geometry
  // [RQ8] address selects row
  assign flash_panel = {r_reg.addr_high,
    r_reg.addr_low[15:flash_seq_pkg::PANEL_ADDR_LSB]};
  assign flash_row = r_reg.addr_low
    [flash_seq_pkg::PANEL_ADDR_LSB-1:flash_seq_pkg::ROW_ADDR_LSB];
  // [RQ3] commit all 32 latches
  assign flash_row_data = r_reg.latch;

endmodule
`default_nettype wire

/* File: logic/flash_cpu_end.sv */
// CPU end: APB commands to register and table writes
//
// Chosen here: the APB register port and the register addresses.
`default_nettype none
module flash_cpu_end (
  input wire logic clk,
  input wire logic rst,
  flash_cpu_if.cpu_end bus,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [2:0] {
    h_idle = 3'b000,
    h_issue = 3'b001,
    h_guard = 3'b011,
    h_nop = 3'b010,
    h_wait = 3'b110
  } host_state_type;

  typedef enum logic [1:0] {job_erase, job_program, job_load} job_type;

  typedef struct packed {
    logic last;
    logic is_table;
    logic high;
    flash_seq_pkg::sfr_sel_type sel;
    logic [15:0] data;
  } step_type;

  typedef struct packed {
    host_state_type state;
    job_type job;
    logic [2:0] step;
    logic last;
    logic [1:0] nops;
    logic [23:0] pointer;
    logic [23:0] data;
    logic [5:0] fill;
    logic align_err;
    logic refused;
    logic [31:0] prdata;
    logic sfr_wr;
    flash_seq_pkg::sfr_sel_type sfr_sel;
    logic [15:0] sfr_wdata;
    logic tbl_wr;
    logic tbl_high;
    logic [23:0] tbl_addr;
    logic [15:0] tbl_wdata;
  } host_regs_type;

  host_regs_type r_reg;
  host_regs_type r_next;
  step_type st;
  logic busy;
  logic mapped;
  logic wr_commit;

  // ****************************************
  // Step table
  // ****************************************
  function automatic step_type job_step(input job_type j, input logic [2:0] s,
      input logic [23:0] ptr, input logic [23:0] d);
    step_type t;
    t = '0;
    t.sel = flash_seq_pkg::sel_control;
    case (j)
      job_load: begin
        // [RQ6] low then high per instruction
        t.is_table = 1'b1;
        t.high = s[0];
        t.last = s[0];
        t.data = s[0] ? {8'h00, d[23:16]} : d[15:0];
      end
      job_erase: begin
        // [RQ15] erase order
        case (s)
          3'h0: t.data = flash_seq_pkg::CTRL_ERASE_CMD;
          3'h1: begin
            t.sel = flash_seq_pkg::sel_addr_high;
            t.data = {8'h00, ptr[23:16]};
          end
          3'h2: begin
            t.sel = flash_seq_pkg::sel_addr_low;
            t.data = ptr[15:0];
          end
          3'h3: begin
            t.sel = flash_seq_pkg::sel_key;
            t.data = {8'h00, flash_seq_pkg::KEY_FIRST};
          end
          3'h4: begin
            t.sel = flash_seq_pkg::sel_key;
            t.data = {8'h00, flash_seq_pkg::KEY_SECOND};
          end
          default: begin
            t.data = flash_seq_pkg::CTRL_ERASE_CMD | flash_seq_pkg::START_MASK;
            t.last = 1'b1;
          end
        endcase
      end
      default: begin
        // [RQ16] program order
        case (s)
          3'h0: t.data = flash_seq_pkg::CTRL_PROGRAM_CMD;
          3'h1: begin
            t.sel = flash_seq_pkg::sel_key;
            t.data = {8'h00, flash_seq_pkg::KEY_FIRST};
          end
          3'h2: begin
            t.sel = flash_seq_pkg::sel_key;
            t.data = {8'h00, flash_seq_pkg::KEY_SECOND};
          end
          default: begin
            t.data = flash_seq_pkg::CTRL_PROGRAM_CMD | flash_seq_pkg::START_MASK;
            t.last = 1'b1;
          end
        endcase
      end
    endcase
    return t;
  endfunction

  // ****************************************
  // APB decode
  // ****************************************
  assign busy = r_reg.state != h_idle;
  assign mapped = paddr == flash_seq_pkg::CMD_OFF || paddr == flash_seq_pkg::ADDR_OFF ||
    paddr == flash_seq_pkg::DATA_OFF || paddr == flash_seq_pkg::STATUS_OFF;
  // Command writes wait for the job, not dropped
  assign pready = !(psel && pwrite && busy && paddr != flash_seq_pkg::STATUS_OFF);
  assign pslverr = psel && penable && pready && !mapped;
  assign wr_commit = psel && penable && pwrite && pready;
  assign st = job_step(r_reg.job, r_reg.step, r_reg.pointer, r_reg.data);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    r_next = r_reg;
    r_next.sfr_wr = 1'b0;
    r_next.tbl_wr = 1'b0;
    if (psel && !penable) begin
      if (paddr == flash_seq_pkg::ADDR_OFF) begin
        r_next.prdata = {8'h00, r_reg.pointer};
      end else if (paddr == flash_seq_pkg::STATUS_OFF) begin
        r_next.prdata = {bus.sfr_rdata, 2'b00, r_reg.fill, 5'h00, r_reg.refused,
          r_reg.align_err, busy};
      end else begin
        r_next.prdata = 32'h0;
      end
    end
    if (wr_commit && paddr == flash_seq_pkg::STATUS_OFF) begin
      if (pwdata[flash_seq_pkg::ST_ALIGN_BIT]) r_next.align_err = 1'b0;
      if (pwdata[flash_seq_pkg::ST_REFUSED_BIT]) r_next.refused = 1'b0;
    end
    case (r_reg.state)
      h_idle: begin
        r_next.step = 3'h0;
        if (wr_commit && paddr == flash_seq_pkg::CMD_OFF) begin
          if (pwdata[flash_seq_pkg::CMD_ERASE_BIT]) begin
            r_next.job = job_erase;
            r_next.state = h_issue;
          end else if (pwdata[flash_seq_pkg::CMD_PROGRAM_BIT]) begin
            // [RQ4] full latches before program
            if (r_reg.fill == flash_seq_pkg::ROW_FULL) begin
              r_next.job = job_program;
              r_next.state = h_issue;
            end else begin
              r_next.refused = 1'b1;
            end
          end
        end else if (wr_commit && paddr == flash_seq_pkg::ADDR_OFF) begin
          r_next.pointer = pwdata[23:0];
          r_next.fill = 6'h00;
        end else if (wr_commit && paddr == flash_seq_pkg::DATA_OFF) begin
          // [RQ5] aligned row start
          if (r_reg.fill == 6'h00 && r_reg.pointer[flash_seq_pkg::ROW_ADDR_LSB-1:0] != 6'h00) begin
            r_next.align_err = 1'b1;
          end else if (r_reg.fill == flash_seq_pkg::ROW_FULL) begin
            r_next.refused = 1'b1;
          end else begin
            r_next.job = job_load;
            r_next.data = pwdata[23:0];
            r_next.state = h_issue;
          end
        end
      end
      h_issue: begin
        r_next.sfr_wr = !st.is_table;
        r_next.tbl_wr = st.is_table;
        r_next.sfr_sel = st.sel;
        r_next.sfr_wdata = st.data;
        r_next.tbl_high = st.high;
        r_next.tbl_addr = r_reg.pointer;
        r_next.tbl_wdata = st.data;
        r_next.last = st.last;
        r_next.nops = 2'h0;
        r_next.state = h_guard;
      end
      h_guard: begin
        r_next.state = (r_reg.last && r_reg.job != job_load) ? h_nop : h_wait;
      end
      h_nop: begin
        // [RQ18] two idle cycles after start
        if (r_reg.nops == flash_seq_pkg::NOP_LAST) begin
          r_next.state = h_wait;
        end else begin
          r_next.nops = r_reg.nops + 2'h1;
        end
      end
      h_wait: begin
        if (!bus.stall) begin
          if (r_reg.last) begin
            r_next.state = h_idle;
            r_next.sfr_sel = flash_seq_pkg::sel_control;
            if (r_reg.job == job_load) begin
              // [RQ4] ascending fill
              r_next.pointer = r_reg.pointer + flash_seq_pkg::INSTR_ADDR_STEP;
              r_next.fill = r_reg.fill + 6'h01;
            end else if (r_reg.job == job_program) begin
              r_next.fill = 6'h00;
            end
          end else begin
            r_next.step = r_reg.step + 3'h1;
            r_next.state = h_issue;
          end
        end
      end
      default: begin
        r_next.state = h_idle;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign prdata = r_reg.prdata;
  assign bus.sfr_wr = r_reg.sfr_wr;
  assign bus.sfr_sel = r_reg.sfr_sel;
  assign bus.sfr_wdata = r_reg.sfr_wdata;
  assign bus.tbl_wr = r_reg.tbl_wr;
  assign bus.tbl_high = r_reg.tbl_high;
  assign bus.tbl_addr = r_reg.tbl_addr;
  assign bus.tbl_wdata = r_reg.tbl_wdata;

endmodule
`default_nettype wire

/* File: test/flash_seq_sva.sv */
// Concurrent checks on the link between the two ends
`default_nettype none
module flash_seq_sva #(
  parameter int OP_CYCLES = flash_seq_pkg::OP_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sfr_wr,
  input wire flash_seq_pkg::sfr_sel_type sfr_sel,
  input wire logic [15:0] sfr_wdata,
  input wire logic [15:0] sfr_rdata,
  input wire logic tbl_wr,
  input wire logic tbl_high,
  input wire logic [23:0] tbl_addr,
  input wire logic [15:0] tbl_wdata,
  input wire logic stall
);
  // ****************************************
  // Unlock tracking and stall run length
  // ****************************************
  logic [1:0] keys_reg;
  logic [31:0] run_reg;
  logic taken;
  logic go;
  logic kw;
  assign taken = (sfr_wr || tbl_wr) && !stall;
  assign kw = !tbl_wr && sfr_sel == flash_seq_pkg::sel_key;
  // Start allowed only right after a full key pair
  assign go = taken && !tbl_wr && sfr_sel == flash_seq_pkg::sel_control && sfr_wdata[15]
    && sfr_wdata[14] && keys_reg == flash_seq_pkg::KEY_OPEN
    && (sfr_wdata[6:0] == flash_seq_pkg::OP_ERASE_ROW
    || sfr_wdata[6:0] == flash_seq_pkg::OP_PROGRAM_ROW);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      keys_reg <= flash_seq_pkg::KEY_NONE;
      run_reg <= 32'h0;
    end else begin
      run_reg <= stall ? run_reg + 32'h1 : 32'h0;
      if (taken) begin
        if (kw && sfr_wdata[7:0] == flash_seq_pkg::KEY_FIRST) begin
          keys_reg <= flash_seq_pkg::KEY_HALF;
        end else if (kw && sfr_wdata[7:0] == flash_seq_pkg::KEY_SECOND
            && keys_reg == flash_seq_pkg::KEY_HALF) begin
          keys_reg <= flash_seq_pkg::KEY_OPEN;
        end else begin
          keys_reg <= flash_seq_pkg::KEY_NONE;
        end
      end
    end
  end
  // ****************************************
  // Assertions
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  tbl_stall_a: assert property (tbl_wr && !stall |=> stall ##1 !stall)
    else $error("table write stall not one cycle");
  unlock_start_a: assert property (go |=> stall [*8])
    else $error("unlocked start did not stall");
  start_refused_a: assert property (taken && !tbl_wr && !go |=> !stall)
    else $error("stall after a non-start write");
  stall_cause_a: assert property ($rose(stall) |-> $past(taken))
    else $error("stall rose with no accepted write");
  op_length_a: assert property ($fell(stall) |-> run_reg == 32'h1 || run_reg == OP_CYCLES)
    else $error("stall length is wrong");
  key_read_a: assert property ($past(sfr_sel) == flash_seq_pkg::sel_key |-> sfr_rdata == 16'h0)
    else $error("key register reads nonzero");
  start_clear_a: assert property ($past(sfr_sel) == flash_seq_pkg::sel_control
    && $past(stall) == 1'b0 |-> (sfr_rdata & 16'hbf80) == 16'h0)
    else $error("control reads set bits while idle");
  high_width_a: assert property ($past(sfr_sel) == flash_seq_pkg::sel_addr_high
    |-> sfr_rdata[15:8] == 8'h0)
    else $error("high address wider than a byte");
  cover property (go && sfr_wdata[6:0] == flash_seq_pkg::OP_ERASE_ROW);
  cover property (go && sfr_wdata[6:0] == flash_seq_pkg::OP_PROGRAM_ROW);
  cover property (tbl_wr && tbl_high && !stall);
endmodule
`default_nettype wire

/* File: test/program_flash_self_write_sequencer_tb_top.sv */
// Testbench for both ends, driven over APB
`default_nettype none
module program_flash_self_write_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Harness
  // ****************************************
  // Short timed cycle keeps the run small
  localparam int OPC = 20;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, erase_go, prog_go, busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [10:0] panel, seen_panel;
  logic [6:0] row, seen_row;
  logic [767:0] row_data, seen_data;
  int n_mismatch = 0;
  int n_compared = 0;
  int n_erase = 0, n_prog = 0, n_busy = 0;
  flash_cpu_if cif();
  flash_self_write_sequencer #(.OP_CYCLES(OPC)) flash_self_write_sequencer_i (.clk(clk),
    .rst(rst), .bus(cif), .flash_erase_start(erase_go), .flash_program_start(prog_go),
    .flash_busy(busy), .flash_panel(panel), .flash_row(row), .flash_row_data(row_data));
  flash_cpu_end flash_cpu_end_i (.clk(clk), .rst(rst), .bus(cif), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  flash_seq_sva #(.OP_CYCLES(OPC)) flash_seq_sva_i (.clk(clk), .rst(rst), .sfr_wr(cif.sfr_wr),
    .sfr_sel(cif.sfr_sel), .sfr_wdata(cif.sfr_wdata), .sfr_rdata(cif.sfr_rdata),
    .tbl_wr(cif.tbl_wr), .tbl_high(cif.tbl_high), .tbl_addr(cif.tbl_addr),
    .tbl_wdata(cif.tbl_wdata), .stall(cif.stall));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (erase_go || prog_go) begin
      seen_panel <= panel;
      seen_row <= row;
      seen_data <= row_data;
    end
    if (erase_go) n_erase <= n_erase + 1;
    if (prog_go) n_prog <= n_prog + 1;
    if (busy) n_busy <= n_busy + 1;
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic print_verdict;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic timeout;
    n_mismatch++;
    $display("BAD t=%0t wait ran out", $time);
    print_verdict();
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Request held until pready is high at an edge
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int k = 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      k++;
      if (k > 2000) timeout();
      @(posedge clk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(a, 1'b1, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    apb(a, 1'b0, 32'h0, q, e);
  endtask
  task automatic wait_idle(output logic [31:0] s);
    int k = 0;
    s = 32'h1;
    while (s[0] !== 1'b0) begin
      k++;
      if (k > 300) timeout();
      rd(flash_seq_pkg::STATUS_OFF, s);
    end
  endtask
  function automatic logic [23:0] instr(input int i);
    return {8'h5a ^ 8'(i), 8'hc3, 8'(i) ^ 8'h0f};
  endfunction
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    logic [31:0] q;
    logic e;
    rd(flash_seq_pkg::STATUS_OFF, q);
    check(q, 32'h0);
    apb(12'h010, 1'b0, 32'h0, q, e);
    check(32'(e), 32'h1);
    $display("test reset done");
  endtask
  task automatic t_erase;
    logic [23:0] a;
    logic [31:0] s;
    int nb;
    a = 24'h7ac0c0;
    nb = n_busy;
    wr(flash_seq_pkg::ADDR_OFF, 32'(a));
    wr(flash_seq_pkg::CMD_OFF, 32'h1);
    wait_idle(s);
    check(32'(n_erase), 32'h1);
    check(32'(seen_panel), 32'(a[23:13]));
    check(32'(seen_row), 32'(a[12:6]));
    check(32'(n_busy - nb), 32'(OPC));
    check(32'(s[31:16]), 32'h4041);
    $display("test erase done");
  endtask
  task automatic t_program;
    logic [23:0] a;
    logic [31:0] s;
    a = 24'h004000;
    wr(flash_seq_pkg::ADDR_OFF, 32'(a));
    // Junk upper byte must never reach a latch
    for (int i = 0; i < 32; i++) wr(flash_seq_pkg::DATA_OFF, {8'hee, instr(i)});
    wr(flash_seq_pkg::DATA_OFF, 32'h00123456);
    wait_idle(s);
    check(32'(s[2]), 32'h1);
    wr(flash_seq_pkg::STATUS_OFF, 32'h6);
    wr(flash_seq_pkg::CMD_OFF, 32'h2);
    wait_idle(s);
    check(32'(n_prog), 32'h1);
    for (int i = 0; i < 32; i++) check(32'(seen_data[24*i +: 24]), 32'(instr(i)));
    check(32'(seen_panel), 32'(a[23:13]));
    check(32'(seen_row), 32'(a[12:6]));
    check(32'(s[31:16]), 32'h4001);
    $display("test program done");
  endtask
  task automatic t_refuse;
    logic [31:0] s;
    wr(flash_seq_pkg::ADDR_OFF, 32'h000042);
    wr(flash_seq_pkg::DATA_OFF, 32'h00abcdef);
    wait_idle(s);
    check(32'(s[1]), 32'h1);
    wr(flash_seq_pkg::STATUS_OFF, 32'h6);
    wr(flash_seq_pkg::ADDR_OFF, 32'h000080);
    wr(flash_seq_pkg::DATA_OFF, 32'h00abcdef);
    wr(flash_seq_pkg::CMD_OFF, 32'h2);
    wait_idle(s);
    check(32'(s[2:1]), 32'h2);
    check(32'(n_prog), 32'h1);
    $display("test refuse done");
  endtask
  initial begin
    rst = 1'b1;
    paddr = 12'h000;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_erase();
    t_program();
    t_refuse();
    print_verdict();
  end
endmodule
`default_nettype wire
